/* File: hw/rtc_pkg.sv */
// Shared types and constants of the backup-domain calendar clock
`default_nettype none
package rtc_pkg;
	// Calendar image; ssec counts down from the prescale value
	typedef struct packed {
		logic [14:0] ssec;
		logic pm;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [2:0] wday;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] year;
	} cal_t;
	// Slow clock source choices
	typedef enum logic [1:0] {SRC_XTAL, SRC_OSC, SRC_LSI, SRC_HSE} src_t;
	localparam int BKP_NUM = 16;
	localparam int BKP_W = 32;
	localparam int TAMP_NUM = 3;
	localparam int WUT_W = 17;
	localparam int SHIFT_W = 15;
	localparam int CAL_WIN_W = 20;
	localparam int CAL_W = 9;
	localparam int FILT_W = 4;
	localparam logic [4:0] HSE_DIV_LAST = 5'h1F;
	localparam logic [5:0] REF50_LAST = 6'h31;
	localparam logic [5:0] REF60_LAST = 6'h3B;
	localparam logic [7:0] SEC_LAST = 8'h59;
	localparam logic [7:0] HOUR24_LAST = 8'h23;
	localparam logic [7:0] HOUR12_LAST = 8'h12;
	localparam logic [7:0] HOUR_11 = 8'h11;
	localparam logic [7:0] HOUR_1 = 8'h01;
	localparam logic [7:0] MONTH_LAST = 8'h12;
	localparam logic [7:0] YEAR_LAST = 8'h99;
	localparam logic [7:0] ONE_BCD = 8'h01;
	localparam logic [7:0] ZERO_BCD = 8'h00;
	localparam logic [2:0] WDAY_FIRST = 3'h1;
	localparam logic [2:0] WDAY_LAST = 3'h7;
	localparam logic [14:0] PRE_RST = 15'h7FFF;
	// Sync bit positions of the pin vector
	localparam int P_XTAL = 0;
	localparam int P_OSC = 1;
	localparam int P_LSI = 2;
	localparam int P_HSE = 3;
	localparam int P_REF = 4;
	localparam int P_TS = 5;
	localparam int P_TAMP = 6;
	localparam int PINS = 9;
endpackage
`default_nettype wire

/* File: hw/bcd_rtc.sv */
// Calendar clock with alarms, tamper, timestamp, wake-up and backup words
// What this block does
// [R1] Sixteen 32-bit backup words give 64 bytes of retained storage.
// [R2] Backup words are never cleared by any reset or wake-up.
// [R3] The calendar holds BCD fields with 12-hour or 24-hour hours.
// [R4] The date wraps at 28, 29 in leap years, 30 or 31 automatically.
// [R5] A 50 Hz or 60 Hz reference can replace the second source.
// [R6] Two alarms raise events that drive the wake output.
// [R7] A shift request swallows 1 to 32767 slow clock pulses on the fly.
// [R8] Calibration adds or drops pulses per 2^20 window, about 1 ppm.
// [R9] Three filtered tamper inputs raise events that drive wake.
// [R10] Timestamp pin or tamper captures the calendar and drives wake.
// [R11] A 17-bit reloading counter flags each expiry and drives wake.
// [R12] The slow clock is crystal, oscillator, RC or fast clock over 32.
// [R13] Fields carry in order, digits roll at decimal limits.
// [R14] Alarm flags are sticky until cleared; a set wins over a clear.
`default_nettype none
module bcd_rtc #(
	parameter int NUM_BKP = rtc_pkg::BKP_NUM
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic xtal_in,
	input wire logic osc_in,
	input wire logic lsi_in,
	input wire logic hse_in,
	input wire logic ref_in,
	input wire logic ts_in,
	input wire logic [rtc_pkg::TAMP_NUM-1:0] tamp_in,
	input wire rtc_pkg::src_t src_sel,
	input wire logic [14:0] prediv,
	input wire logic fmt12,
	input wire logic time_load,
	input wire rtc_pkg::cal_t time_in,
	input wire logic ref_en,
	input wire logic ref_60,
	input wire logic cal_neg,
	input wire logic [rtc_pkg::CAL_W-1:0] cal_val,
	input wire logic shift_req,
	input wire logic shift_add1s,
	input wire logic [rtc_pkg::SHIFT_W-1:0] shift_val,
	input wire logic [1:0] alm_en,
	input wire rtc_pkg::cal_t alm0,
	input wire rtc_pkg::cal_t alm1,
	input wire logic [1:0] alm_clr,
	input wire logic [rtc_pkg::TAMP_NUM-1:0] tamp_en,
	input wire logic [1:0] tamp_filt,
	input wire logic [rtc_pkg::TAMP_NUM-1:0] tamp_clr,
	input wire logic ts_en,
	input wire logic ts_on_tamp,
	input wire logic ts_clr,
	input wire logic wut_en,
	input wire logic [rtc_pkg::WUT_W-1:0] wut_reload,
	input wire logic wut_clr,
	input wire logic bkp_we,
	input wire logic [3:0] bkp_waddr,
	input wire logic [rtc_pkg::BKP_W-1:0] bkp_wdata,
	input wire logic [3:0] bkp_raddr,
	output logic [rtc_pkg::BKP_W-1:0] bkp_rdata,
	output rtc_pkg::cal_t cal_o,
	output rtc_pkg::cal_t ts_o,
	output logic [1:0] alarm_flag,
	output logic [rtc_pkg::TAMP_NUM-1:0] tamp_flag,
	output logic ts_flag,
	output logic wut_flag,
	output logic wake
);
	import rtc_pkg::*;

	if (NUM_BKP != BKP_NUM) begin : g_chk
		$error("bcd_rtc: backup bank must hold sixteen words");
	end

	typedef struct packed {
		logic [PINS-1:0] s1, s2, s3;
		logic [4:0] hdiv;
		logic [14:0] pre;
		logic [CAL_WIN_W-1:0] win;
		logic [SHIFT_W-1:0] shift;
		logic [5:0] refc;
		cal_t cal;
		cal_t ts;
		logic [1:0] alrm;
		logic [TAMP_NUM-1:0] tamp;
		logic tsf, wutf, wake;
		logic [WUT_W-1:0] wut;
		logic [TAMP_NUM-1:0][FILT_W-1:0] filt;
	} st_t;

	st_t r_r, r_nxt;
	logic [BKP_W-1:0] bkp_mem [BKP_NUM];
	logic [BKP_W-1:0] bkp_rdata_r;

	// BCD step of one field: carry and next value
	function automatic logic [8:0] bcd_inc(logic [7:0] v, logic [7:0] lo,
			logic [7:0] hi);
		if (v == hi)
			return {1'b1, lo};
		if (v[3:0] == 4'h9)
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		return {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction

	// Last day of a month, leap years every fourth BCD year
	function automatic logic [7:0] mdays(logic [7:0] m, logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
			(y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		unique case (m)
			8'h02: return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// Alarm match on every field but subsecond and weekday
	function automatic logic match(cal_t a, cal_t b);
		return a.sec == b.sec && a.min == b.min && a.hour == b.hour &&
			a.pm == b.pm && a.date == b.date && a.month == b.month &&
			a.year == b.year;
	endfunction

	logic [PINS-1:0] rise;
	logic raw, eff, dbl, tick, add_sec, day;
	logic [8:0] c;
	logic [3:0] lim;
	logic [TAMP_NUM-1:0] tev;
	logic tsev;

	// Next state of the whole clock
	always_comb begin
		r_nxt = r_r;
		c = '0;
		day = 1'b0;
		r_nxt.s1 = {tamp_in, ts_in, ref_in, hse_in, lsi_in, osc_in, xtal_in};
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		rise = r_r.s2 & ~r_r.s3;
		// [R12] source select
		unique case (src_sel)
			SRC_XTAL: raw = rise[P_XTAL];
			SRC_OSC: raw = rise[P_OSC];
			SRC_LSI: raw = rise[P_LSI];
			SRC_HSE: raw = rise[P_HSE] && r_r.hdiv == HSE_DIV_LAST;
		endcase
		if (rise[P_HSE])
			r_nxt.hdiv = r_r.hdiv + 5'h1;
		// [R8] ppm calibration window
		eff = raw;
		dbl = 1'b0;
		if (raw) begin
			r_nxt.win = r_r.win + CAL_WIN_W'(1);
			if (r_r.win < CAL_WIN_W'(cal_val)) begin
				eff = ~cal_neg;
				dbl = ~cal_neg;
			end
		end
		// [R7] shift swallows pulses
		if (raw && r_r.shift != '0) begin
			eff = 1'b0;
			r_nxt.shift = r_r.shift - SHIFT_W'(1);
		end
		add_sec = shift_req && shift_add1s;
		if (shift_req)
			r_nxt.shift = shift_val;
		// Prescaler makes the second tick
		tick = 1'b0;
		if (eff) begin
			if (r_r.pre == '0 || (dbl && r_r.pre == 15'h1)) begin
				tick = ~ref_en;
				r_nxt.pre = prediv;
			end else begin
				r_nxt.pre = r_r.pre - (dbl ? 15'h2 : 15'h1);
			end
		end
		// [R5] reference second source
		if (ref_en && rise[P_REF]) begin
			r_nxt.refc = r_r.refc + 6'h1;
			if (r_r.refc == (ref_60 ? REF60_LAST : REF50_LAST)) begin
				r_nxt.refc = '0;
				r_nxt.pre = prediv;
				tick = 1'b1;
			end
		end
		// [R13] carry chain
		if (tick || add_sec) begin
			c = bcd_inc(r_r.cal.sec, ZERO_BCD, SEC_LAST);
			r_nxt.cal.sec = c[7:0];
			if (c[8]) begin
				c = bcd_inc(r_r.cal.min, ZERO_BCD, SEC_LAST);
				r_nxt.cal.min = c[7:0];
			end
			day = 1'b0;
			if (c[8]) begin
				// [R3] 12 or 24 hour stepping
				if (!fmt12) begin
					c = bcd_inc(r_r.cal.hour, ZERO_BCD, HOUR24_LAST);
					r_nxt.cal.hour = c[7:0];
					day = c[8];
				end else if (r_r.cal.hour == HOUR12_LAST) begin
					r_nxt.cal.hour = HOUR_1;
				end else begin
					c = bcd_inc(r_r.cal.hour, HOUR_1, HOUR12_LAST);
					r_nxt.cal.hour = c[7:0];
					if (r_r.cal.hour == HOUR_11) begin
						r_nxt.cal.pm = ~r_r.cal.pm;
						day = r_r.cal.pm;
					end
				end
			end
			if (day) begin
				r_nxt.cal.wday = (r_r.cal.wday == WDAY_LAST) ? WDAY_FIRST :
					r_r.cal.wday + 3'h1;
				// [R4] month length
				c = bcd_inc(r_r.cal.date, ONE_BCD,
					mdays(r_r.cal.month, r_r.cal.year));
				r_nxt.cal.date = c[7:0];
				if (c[8]) begin
					c = bcd_inc(r_r.cal.month, ONE_BCD, MONTH_LAST);
					r_nxt.cal.month = c[7:0];
				end
				if (c[8]) begin
					c = bcd_inc(r_r.cal.year, ZERO_BCD, YEAR_LAST);
					r_nxt.cal.year = c[7:0];
				end
			end
		end
		// Software load wins over the running count
		if (time_load) begin
			r_nxt.cal = time_in;
			r_nxt.pre = prediv;
			r_nxt.shift = '0;
		end
		r_nxt.cal.ssec = r_nxt.pre;
		// [R6] [R14] alarms, set wins over clear
		r_nxt.alrm[0] = (r_r.alrm[0] & ~alm_clr[0]) |
			(alm_en[0] & tick & match(r_nxt.cal, alm0));
		r_nxt.alrm[1] = (r_r.alrm[1] & ~alm_clr[1]) |
			(alm_en[1] & tick & match(r_nxt.cal, alm1));
		// [R9] tamper filter: edge or 2, 4, 8 equal samples
		lim = 4'h1 << tamp_filt;
		for (int i = 0; i < TAMP_NUM; i++) begin
			if (tamp_filt == 2'h0) begin
				tev[i] = rise[P_TAMP + i];
			end else begin
				tev[i] = raw && r_r.s2[P_TAMP + i] && r_r.filt[i] == lim - 4'h1;
				if (!r_r.s2[P_TAMP + i])
					r_nxt.filt[i] = '0;
				else if (raw && r_r.filt[i] != lim)
					r_nxt.filt[i] = r_r.filt[i] + 4'h1;
			end
			tev[i] = tev[i] & tamp_en[i];
			r_nxt.tamp[i] = (r_r.tamp[i] & ~tamp_clr[i]) | tev[i];
		end
		// [R10] timestamp capture
		tsev = ts_en & (rise[P_TS] | (ts_on_tamp & (|tev)));
		if (tsev)
			r_nxt.ts = r_r.cal;
		r_nxt.tsf = (r_r.tsf & ~ts_clr) | tsev;
		// [R11] wake-up counter
		if (!wut_en) begin
			r_nxt.wut = wut_reload;
		end else if (raw) begin
			r_nxt.wut = (r_r.wut == '0) ? wut_reload :
				r_r.wut - WUT_W'(1);
		end
		r_nxt.wutf = (r_r.wutf & ~wut_clr) |
			(wut_en & raw & r_r.wut == '0);
		r_nxt.wake = (|r_nxt.alrm) | (|r_nxt.tamp) | r_nxt.tsf | r_nxt.wutf;
	end

	// State register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r_r <= '0;
			r_r.pre <= PRE_RST;
			r_r.cal.date <= ONE_BCD;
			r_r.cal.month <= ONE_BCD;
			r_r.cal.wday <= WDAY_FIRST;
		end else begin
			r_r <= r_nxt;
		end
	end

	// [R1] [R2] backup bank, no reset of any kind
	always_ff @(posedge clk_sys) begin
		if (bkp_we)
			bkp_mem[bkp_waddr] <= bkp_wdata;
		bkp_rdata_r <= bkp_mem[bkp_raddr];
	end

	assign bkp_rdata = bkp_rdata_r;
	assign cal_o = r_r.cal;
	assign ts_o = r_r.ts;
	assign alarm_flag = r_r.alrm;
	assign tamp_flag = r_r.tamp;
	assign ts_flag = r_r.tsf;
	assign wut_flag = r_r.wutf;
	assign wake = r_r.wake;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_bkp_wr;
		bkp_we && bkp_raddr == bkp_waddr;
	endsequence
	sequence s_bkp_hold;
		!bkp_we && bkp_raddr == $past(bkp_waddr);
	endsequence

	AST_BKP_KEEP: assert property (s_bkp_wr ##1 s_bkp_hold |=> // [R1]
		bkp_rdata == $past(bkp_wdata, 2)) else $error("backup word lost");
	AST_SEC_BCD: assert property ($past(rstn) && !$past(time_load) // [R3]
		|-> cal_o.sec <= SEC_LAST && cal_o.sec[3:0] <= 4'h9)
		else $error("seconds not BCD");
	AST_MONTH_LEN: assert property ($changed(cal_o.date) && // [R4]
		!$past(time_load) |-> cal_o.date <= mdays(cal_o.month, cal_o.year))
		else $error("date past month end");
	AST_CARRY: assert property ($past(cal_o.sec) == SEC_LAST && // [R13]
		cal_o.sec == ZERO_BCD && !$past(time_load) |->
		cal_o.min != $past(cal_o.min)) else $error("minute carry missed");
	AST_ALM_STICKY: assert property (alarm_flag[0] && !alm_clr[0] // [R14]
		|=> alarm_flag[0]) else $error("alarm flag dropped");
	AST_WAKE: assert property (wake == (|alarm_flag || |tamp_flag || // [R6]
		ts_flag || wut_flag)) else $error("wake not tied to events");
	AST_TS_CAPT: assert property ($rose(ts_flag) |-> // [R10]
		ts_o == $past(cal_o) && $past(ts_en)) else $error("stamp wrong");
	AST_SHIFT: assert property (shift_req && !time_load |=> // [R7]
		r_r.shift == $past(shift_val)) else $error("shift not armed");
	AST_TAMP_EN: assert property ($rose(tamp_flag[0]) |-> // [R9]
		$past(tamp_en[0])) else $error("tamper flag while disabled");
	AST_WUT: assert property ($rose(wut_flag) |-> $past(wut_en) && // [R11]
		r_r.wut == $past(wut_reload)) else $error("wake-up not reloaded");
endmodule // bcd_rtc
`default_nettype wire

/* File: dv/rtc_pins.sv */
// Free-running slow clock sources and mains reference for the bench
`default_nettype none
module rtc_pins #(
	parameter int XTAL_HP = 50,
	parameter int OSC_HP = 60,
	parameter int LSI_HP = 45,
	parameter int HSE_HP = 10,
	parameter int REF_HP = 20
) (
	output logic xtal_in,
	output logic osc_in,
	output logic lsi_in,
	output logic hse_in,
	output logic ref_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// All sources start low, then run free at unrelated rates
	logic xtal_r = 1'h0;
	logic osc_r = 1'h0;
	logic lsi_r = 1'h0;
	logic hse_r = 1'h0;
	logic ref_r = 1'h0;
	always #(XTAL_HP) xtal_r = ~xtal_r;
	always #(OSC_HP) osc_r = ~osc_r;
	always #(LSI_HP) lsi_r = ~lsi_r;
	always #(HSE_HP) hse_r = ~hse_r;
	always #(REF_HP) ref_r = ~ref_r;
	// One process drives each pin
	assign xtal_in = xtal_r;
	assign osc_in = osc_r;
	assign lsi_in = lsi_r;
	assign hse_in = hse_r;
	assign ref_in = ref_r;
endmodule // rtc_pins
`default_nettype wire

/* File: dv/tb_bcd_rtc.sv */
// Self-checking bench of the calendar clock block
`default_nettype none
module tb_bcd_rtc;
	timeunit 1ns;
	timeprecision 1ps;
	import rtc_pkg::*;
	logic clk_sys = 1'h0, rstn = 1'h0, ts_in = 1'h0, fmt12 = 1'h0;
	logic time_load = 1'h0, ref_en = 1'h0, ref_60 = 1'h0, cal_neg = 1'h0;
	logic shift_req = 1'h0, shift_add1s = 1'h0, ts_en = 1'h0;
	logic ts_on_tamp = 1'h0, ts_clr = 1'h0, wut_en = 1'h0, wut_clr = 1'h0;
	logic bkp_we = 1'h0, ts_flag, wut_flag, wake;
	logic xtal_in, osc_in, lsi_in, hse_in, ref_in;
	logic [2:0] tamp_in = 3'h0, tamp_en = 3'h0, tamp_clr = 3'h0, tamp_flag;
	logic [1:0] alm_en = 2'h0, alm_clr = 2'h0, tamp_filt = 2'h0, alarm_flag;
	logic [14:0] prediv = 15'h0003, shift_val = 15'h0000;
	logic [8:0] cal_val = 9'h000;
	logic [16:0] wut_reload = 17'h00002;
	logic [3:0] bkp_waddr = 4'h0, bkp_raddr = 4'h0;
	logic [31:0] bkp_wdata = 32'h0, bkp_rdata;
	src_t src_sel = SRC_XTAL;
	cal_t time_in = '0, alm0 = '0, alm1 = '0, cal_o, ts_o;
	cal_t dl [6];
	cal_t de [6];
	int fails = 0, samples_checked = 0;
	bcd_rtc i_bcd_rtc (.clk_sys, .rstn, .xtal_in, .osc_in, .lsi_in,
		.hse_in, .ref_in, .ts_in, .tamp_in, .src_sel, .prediv, .fmt12,
		.time_load, .time_in, .ref_en, .ref_60, .cal_neg, .cal_val,
		.shift_req, .shift_add1s, .shift_val, .alm_en, .alm0, .alm1,
		.alm_clr, .tamp_en, .tamp_filt, .tamp_clr, .ts_en, .ts_on_tamp,
		.ts_clr, .wut_en, .wut_reload, .wut_clr, .bkp_we, .bkp_waddr,
		.bkp_wdata, .bkp_raddr, .bkp_rdata, .cal_o, .ts_o, .alarm_flag,
		.tamp_flag, .ts_flag, .wut_flag, .wake);
	rtc_pins i_rtc_pins (.xtal_in, .osc_in, .lsi_in, .hse_in, .ref_in);
	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;
	function automatic cal_t mk(logic [7:0] h, m, s, d, mo, y,
		logic [2:0] w, logic p);
		return '{15'h0, p, s, m, h, w, d, mo, y};
	endfunction
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask
	// Subsecond depends on prescaler phase, so it is left out
	task automatic chk_cal(input cal_t got, input cal_t exp);
		got.ssec = '0;
		exp.ssec = '0;
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t calendar %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_reset();
		@(negedge clk_sys);
		rstn = 1'h0;
		repeat (8) @(negedge clk_sys);
		rstn = 1'h1;
	endtask
	task automatic load(input cal_t t);
		@(negedge clk_sys);
		time_in = t;
		time_load = 1'h1;
		@(negedge clk_sys);
		time_load = 1'h0;
	endtask
	// Bounded wait for the seconds field to move
	task automatic wait_sec();
		logic [7:0] s;
		s = cal_o.sec;
		for (int i = 0; i < 600 && cal_o.sec === s; i++) @(negedge clk_sys);
	endtask
	task automatic pulse_clr();
		@(negedge clk_sys);
		{alm_clr, tamp_clr, ts_clr, wut_clr} = 7'h7F;
		@(negedge clk_sys);
		{alm_clr, tamp_clr, ts_clr, wut_clr} = 7'h00;
		@(negedge clk_sys);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#300us;
		fails++;
		final_report();
	end
	initial begin
		dl[0] = mk(8'h23, 8'h59, 8'h59, 8'h28, 8'h02, 8'h01, 3'h7, 1'h0);
		de[0] = mk(8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h01, 3'h1, 1'h0);
		dl[1] = mk(8'h23, 8'h59, 8'h59, 8'h28, 8'h02, 8'h04, 3'h3, 1'h0);
		de[1] = mk(8'h00, 8'h00, 8'h00, 8'h29, 8'h02, 8'h04, 3'h4, 1'h0);
		dl[2] = mk(8'h23, 8'h59, 8'h59, 8'h30, 8'h04, 8'h05, 3'h2, 1'h0);
		de[2] = mk(8'h00, 8'h00, 8'h00, 8'h01, 8'h05, 8'h05, 3'h3, 1'h0);
		dl[3] = mk(8'h23, 8'h59, 8'h59, 8'h31, 8'h12, 8'h99, 3'h5, 1'h0);
		de[3] = mk(8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 3'h6, 1'h0);
		dl[4] = mk(8'h11, 8'h59, 8'h59, 8'h09, 8'h09, 8'h09, 3'h1, 1'h0);
		de[4] = mk(8'h12, 8'h00, 8'h00, 8'h09, 8'h09, 8'h09, 3'h1, 1'h1);
		dl[5] = mk(8'h11, 8'h59, 8'h59, 8'h09, 8'h09, 8'h09, 3'h1, 1'h1);
		de[5] = mk(8'h12, 8'h00, 8'h00, 8'h10, 8'h09, 8'h09, 3'h2, 1'h0);
		do_reset();
		// Subsecond follows the prescaler from the first edge on
		@(negedge clk_sys);
		chk_cal(cal_o, mk(8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 3'h1, 1'h0));
		chk_w(cal_o.ssec, 32'h7FFF);
		// Backup words filled, read back after a later reset
		for (int i = 0; i < 16; i++) begin
			@(negedge clk_sys);
			{bkp_we, bkp_waddr, bkp_raddr} = {1'h1, 4'(i), 4'(i)};
			bkp_wdata = {28'hC0FFEE0, 4'(i)}; // Read follows write
		end
		@(negedge clk_sys);
		bkp_we = 1'h0;
		{alm0, alm1, alm_en} = {de[0], de[5], 2'h3};
		// Month lengths, leap year, century wrap and 12-hour stepping
		for (int i = 0; i < 6; i++) begin
			fmt12 = (i >= 4);
			load(dl[i]);
			wait_sec();
			chk_cal(cal_o, de[i]);
			chk_w(alarm_flag, {30'h0, i == 5, i == 0});
			chk_w(wake, (i == 0 || i == 5));
			pulse_clr();
			chk_w(alarm_flag, 32'h0);
		end
		{fmt12, alm_en} = 3'h0;
		// Every clock source, then both mains rates, gives one second
		for (int k = 0; k < 6; k++) begin
			src_sel = (k < 4) ? src_t'(k) : SRC_XTAL;
			{ref_en, ref_60} = {k >= 4, k == 5};
			load(mk(8'h01, 8'h00, 8'h00, 8'h15, 8'h06, 8'h20, 3'h2, 1'h0));
			wait_sec();
			chk_cal(cal_o, mk(8'h01, 8'h00, 8'h01, 8'h15, 8'h06, 8'h20, 3'h2, 1'h0));
		end
		ref_en = 1'h0;
		load(mk(8'h10, 8'h00, 8'h00, 8'h15, 8'h06, 8'h20, 3'h2, 1'h0));
		{shift_req, shift_add1s, shift_val} = {2'h3, 15'h0005};
		@(negedge clk_sys);
		{shift_req, shift_add1s} = 2'h0;
		@(negedge clk_sys);
		chk_w(cal_o.sec, 32'h01);
		// Tamper raises flag, wake and a timestamp of the calendar
		{tamp_en, ts_en, ts_on_tamp} = 5'h1F;
		tamp_in = 3'h2;
		repeat (5) @(negedge clk_sys);
		chk_w(tamp_flag, 32'h2);
		chk_w({ts_flag, wake}, 32'h3);
		chk_cal(ts_o, mk(8'h10, 8'h00, 8'h01, 8'h15, 8'h06, 8'h20, 3'h2, 1'h0));
		tamp_in = 3'h0;
		pulse_clr();
		ts_in = 1'h1;
		repeat (5) @(negedge clk_sys);
		chk_w({tamp_flag, ts_flag}, 32'h1);
		{ts_in, tamp_filt} = 3'h1;
		pulse_clr();
		tamp_in = 3'h1;
		repeat (2) @(negedge clk_sys);
		tamp_in = 3'h0;
		repeat (5) @(negedge clk_sys);
		chk_w({tamp_flag, wake}, 32'h0);
		// A level held for four slow samples passes the filter
		{tamp_in, tamp_filt} = 5'h06;
		repeat (60) @(negedge clk_sys);
		chk_w(tamp_flag, 32'h1);
		tamp_in = 3'h0;
		pulse_clr();
		// Calibration first drops, then doubles the slow pulses
		{cal_neg, cal_val} = {1'h1, 9'h1FF};
		load(mk(8'h10, 8'h00, 8'h00, 8'h15, 8'h06, 8'h20, 3'h2, 1'h0));
		repeat (60) @(negedge clk_sys);
		chk_w(cal_o.sec, 32'h00);
		cal_neg = 1'h0;
		load(time_in);
		repeat (28) @(negedge clk_sys);
		chk_w(cal_o.sec, 32'h01);
		cal_val = 9'h000;
		wut_en = 1'h1;
		for (int i = 0; i < 100 && wut_flag !== 1'h1; i++) @(negedge clk_sys);
		chk_w({wut_flag, wake}, 32'h3);
		// Counter off, so no expiry follows the reset
		wut_en = 1'h0;
		do_reset();
		for (int i = 0; i < 16; i++) begin
			bkp_raddr = 4'(i);
			@(negedge clk_sys);
			chk_w(bkp_rdata, {28'hC0FFEE0, 4'(i)});
		end
		chk_w({alarm_flag, tamp_flag, ts_flag, wut_flag, wake}, 32'h0);
		final_report();
	end
endmodule // tb_bcd_rtc
`default_nettype wire
